// [dif_pkg.sv]
package dif_pkg;

   // Sizes
   localparam int DIF_NUM_DI = 10;
   localparam int DIF_FUNC_W = 6;
   localparam int DIF_ADDR_W = 8;
   localparam int DIF_DATA_W = 32;
   localparam int DIF_FILT_W = 10;
   localparam int DIF_DIV_W  = 18;

   // Function assignment values
   localparam logic [5:0] DIF_FN_TORQUE_BLOCK = 6'h1D;
   localparam logic [5:0] DIF_FN_PULSE_IN     = 6'h1E;
   localparam logic [5:0] DIF_FN_RESERVED     = 6'h1F;
   localparam logic [5:0] DIF_FN_DC_NOW       = 6'h20;
   localparam logic [5:0] DIF_FN_EXT_FAULT    = 6'h21;
   localparam logic [5:0] DIF_FN_FREQ_LOCK    = 6'h22;
   localparam logic [5:0] DIF_FN_PID_REV      = 6'h23;
   localparam logic [5:0] DIF_FN_PANEL_STOP   = 6'h24;
   localparam logic [5:0] DIF_FN_CMD_SWITCH   = 6'h25;
   localparam logic [5:0] DIF_FN_PID_INT_HOLD = 6'h26;
   localparam logic [5:0] DIF_FN_X_PRESET     = 6'h27;
   localparam logic [5:0] DIF_FN_Y_PRESET     = 6'h28;
   localparam logic [5:0] DIF_FN_MOTOR_BIT0   = 6'h29;
   localparam logic [5:0] DIF_FN_MOTOR_BIT1   = 6'h2A;
   localparam logic [5:0] DIF_FN_PID_GAIN     = 6'h2B;
   localparam logic [5:0] DIF_FN_USER_FAULT1  = 6'h2C;
   localparam logic [5:0] DIF_FN_USER_FAULT2  = 6'h2D;
   localparam logic [5:0] DIF_FN_MODE_SWITCH  = 6'h2E;
   localparam logic [5:0] DIF_FN_ESTOP        = 6'h2F;
   localparam logic [5:0] DIF_FN_DECEL_STOP   = 6'h30;
   localparam logic [5:0] DIF_FN_DECEL_DC     = 6'h31;
   localparam logic [5:0] DIF_FN_RT_CLEAR     = 6'h32;
   localparam logic [5:0] DIF_FN_LINE_SWITCH  = 6'h33;

   // Fifth digital input index
   localparam int DIF_PULSE_DI_IDX = 4;

   // Fault codes
   localparam logic [7:0] DIF_EXTERNAL_FAULT_CODE  = 8'h0F;
   localparam logic [7:0] DIF_USER_FAULT_ONE_CODE  = 8'h1B;
   localparam logic [7:0] DIF_USER_FAULT_TWO_CODE  = 8'h1C;

   // Command sources, modes
   localparam logic [1:0] DIF_CMD_PANEL    = 2'h0;
   localparam logic [1:0] DIF_CMD_TERMINAL = 2'h1;
   localparam logic [1:0] DIF_CMD_COMM     = 2'h2;
   localparam logic [1:0] DIF_TERM_TWO1    = 2'h0;
   localparam logic [1:0] DIF_TERM_THREE1  = 2'h2;
   localparam logic       DIF_MODE_SPEED   = 1'b0;
   localparam logic [1:0] DIF_DECEL_TIME4  = 2'h3;
   localparam logic       DIF_PID_SRC_TERM = 1'b1;

   // Register offsets
   localparam logic [7:0] DIF_REG_FUNC_BASE = 8'h00;
   localparam logic [7:0] DIF_REG_FILTER    = 8'h28;
   localparam logic [7:0] DIF_REG_CONFIG    = 8'h2C;
   localparam logic [7:0] DIF_REG_RT_LIMIT  = 8'h30;
   localparam logic [7:0] DIF_REG_INPUTS    = 8'h34;
   localparam logic [7:0] DIF_REG_STATE     = 8'h38;

   // Config field positions
   localparam int DIF_CFG_PID_DIR  = 0;
   localparam int DIF_CFG_PID_SRC  = 1;
   localparam int DIF_CFG_CTRL     = 2;
   localparam int DIF_CFG_CMD_LO   = 3;
   localparam int DIF_CFG_TERM_LO  = 5;
   localparam int DIF_CFG_RT_EN    = 7;
   localparam int DIF_CFG_ACT_LO   = 8;

   // Reset values
   localparam logic [5:0]  DIF_FUNC_RESET   = 6'h00;
   localparam logic [9:0]  DIF_FILTER_RESET = 10'h00A;
   localparam logic [11:0] DIF_CONFIG_RESET = 12'h000;
   localparam logic [15:0] DIF_RT_RESET     = 16'h0000;

   // Timing
   localparam int DIF_CLK_PERIOD_NS = 4;
   localparam int DIF_MS_IN_NS      = 1000000;
   localparam int DIF_CYC_PER_MS    = DIF_MS_IN_NS / DIF_CLK_PERIOD_NS;

endpackage

// [dif_input_filter.sv]
`timescale 1ns/1ps
module dif_input_filter
   import dif_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Timing
   input  wire logic                  ms_tick,
   input  wire logic [DIF_FILT_W-1:0] filter_ms,
   // Pin and result
   input  wire logic                  raw_in,
   output logic                       state
);
   logic                  sync1;
   logic                  sync2;
   logic [DIF_FILT_W-1:0] cnt;

   // Pin synchroniser
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end
      else
      begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   // Accept a new level once stable for filter_ms
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= 1'b0;
         cnt   <= '0;
      end
      else if (sync2 == state)
         cnt <= '0;
      else if (cnt >= filter_ms)
      begin
         state <= sync2;
         cnt   <= '0;
      end
      else if (ms_tick)
         cnt <= cnt + 1'b1;
   end

endmodule // dif_input_filter

// [dif_decoder.sv]
// Function
// - Function 29 forces speed control mode
// - Pulse input honoured only on fifth input
// - Function 32 rising starts immediate DC braking
// - Function 33 reports external fault and stops
// - Function 34 blocks frequency modification
// - Function 35 inverts configured PID direction
// - Function 36 stops drive in panel mode
// - Function 37 moves terminal source to communication
// - Function 38 pauses PID integral only
// - Functions 39/40 substitute preset for X/Y
// - Functions 41/42 form motor select code
// - Code 00..11 selects motor one..four
// - Function 43 picks PID gain set when PID source is terminal
// - Functions 44/45 raise user faults
// - Function 46 toggles configured control mode
// - Function 47 emergency stop at current limit
// - Function 48 decel stop with time four
// - Function 49 decelerates then DC brakes
// - Function 50 clears running time if enabled and limit nonzero
// - Function 51 turns two-line1 into three-line1
// - Inputs pass configurable millisecond filter
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module dif_decoder
   import dif_pkg::*;
#(
   parameter int CYC_PER_MS = DIF_CYC_PER_MS
)
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Register port
   input  wire logic [DIF_ADDR_W-1:0] reg_addr,
   input  wire logic [DIF_DATA_W-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [DIF_DATA_W-1:0]      reg_rdata,
   // Terminal pins
   input  wire logic [DIF_NUM_DI-1:0] di_pin,
   // Control core
   output logic                       ctrl_mode,
   output logic                       pulse_input_en,
   output logic                       dc_brake_now,
   output logic                       fault_report,
   output logic [7:0]                 fault_code,
   output logic [3:0]                 fault_action,
   output logic                       fault_stop,
   output logic                       freq_mod_block,
   output logic                       pid_reverse,
   output logic                       panel_stop,
   output logic [1:0]                 cmd_source,
   output logic                       pid_int_pause,
   output logic                       freq_x_preset,
   output logic                       freq_y_preset,
   output logic [1:0]                 motor_sel,
   output logic                       pid_gain_set,
   output logic                       estop,
   output logic                       current_limit_hold,
   output logic                       decel_stop,
   output logic [1:0]                 decel_time_sel,
   output logic                       decel_dc_brake,
   output logic                       run_time_clear,
   output logic [1:0]                 term_mode
);
   import dif_pkg::*;

   logic [DIF_FUNC_W-1:0] func_sel [DIF_NUM_DI];
   logic [DIF_FILT_W-1:0] filter_ms;
   logic [11:0]           config_reg;
   logic [15:0]           rt_limit;
   logic [DIF_DIV_W-1:0]  div_cnt;
   logic                  ms_tick;
   logic [DIF_NUM_DI-1:0] di_state;
   logic [63:0]           fn_on;
   logic [63:0]           fn_prev;
   logic [63:0]           fn_rise;
   logic [DIF_DATA_W-1:0] next_rdata;
   logic [1:0]            cfg_cmd;
   logic [1:0]            cfg_term;

   assign cfg_cmd  = config_reg[DIF_CFG_CMD_LO +: 2];
   assign cfg_term = config_reg[DIF_CFG_TERM_LO +: 2];

   // Register writes
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int i = 0; i < DIF_NUM_DI; i++)
            func_sel[i] <= DIF_FUNC_RESET;
         filter_ms  <= DIF_FILTER_RESET;
         config_reg <= DIF_CONFIG_RESET;
         rt_limit   <= DIF_RT_RESET;
      end
      else if (reg_wr)
      begin
         for (int i = 0; i < DIF_NUM_DI; i++)
            if (reg_addr == DIF_REG_FUNC_BASE + 8'(4 * i))
               func_sel[i] <= reg_wdata[DIF_FUNC_W-1:0];
         if (reg_addr == DIF_REG_FILTER)
            filter_ms <= reg_wdata[DIF_FILT_W-1:0];
         if (reg_addr == DIF_REG_CONFIG)
            config_reg <= reg_wdata[11:0];
         if (reg_addr == DIF_REG_RT_LIMIT)
            rt_limit <= reg_wdata[15:0];
      end
   end

   // Read mux
   always_comb
   begin
      next_rdata = '0;
      for (int i = 0; i < DIF_NUM_DI; i++)
         if (reg_addr == DIF_REG_FUNC_BASE + 8'(4 * i))
            next_rdata = {26'h0, func_sel[i]};
      case (reg_addr)
         DIF_REG_FILTER:   next_rdata = {22'h0, filter_ms};
         DIF_REG_CONFIG:   next_rdata = {20'h0, config_reg};
         DIF_REG_RT_LIMIT: next_rdata = {16'h0, rt_limit};
         DIF_REG_INPUTS:   next_rdata = {22'h0, di_state};
         DIF_REG_STATE:    next_rdata = {16'h0, estop, freq_mod_block, pid_int_pause,
                                         pid_reverse, freq_x_preset, freq_y_preset,
                                         pid_gain_set, pulse_input_en, term_mode,
                                         cmd_source, motor_sel, ctrl_mode, fault_code[0]
                                         | fault_code[1] | fault_code[2] | fault_code[3]};
         default:          ;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         reg_rdata <= '0;
      else if (reg_rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= '0;
   end

   // Millisecond enable
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         div_cnt <= '0;
         ms_tick <= 1'b0;
      end
      else if (div_cnt == DIF_DIV_W'(CYC_PER_MS - 1))
      begin
         div_cnt <= '0;
         ms_tick <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
         ms_tick <= 1'b0;
      end
   end

   // Input filters
   for (genvar g = 0; g < DIF_NUM_DI; g++)
   begin : g_filt
      dif_input_filter u_filt (
         .clk_sys   (clk_sys),
         .rst       (rst),
         .ms_tick   (ms_tick),
         .filter_ms (filter_ms),
         .raw_in    (di_pin[g]),
         .state     (di_state[g])
      );
   end

   // Function activity; unlisted values never read
   always_comb
   begin
      fn_on = '0;
      for (int i = 0; i < DIF_NUM_DI; i++)
         if (di_state[i] && (func_sel[i] != DIF_FN_PULSE_IN || i == DIF_PULSE_DI_IDX))
            fn_on[func_sel[i]] = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         fn_prev <= '0;
      else
         fn_prev <= fn_on;
   end

   assign fn_rise = fn_on & ~fn_prev;

   // Level controls
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl_mode          <= DIF_MODE_SPEED;
         pulse_input_en     <= 1'b0;
         freq_mod_block     <= 1'b0;
         pid_reverse        <= 1'b0;
         pid_int_pause      <= 1'b0;
         freq_x_preset      <= 1'b0;
         freq_y_preset      <= 1'b0;
         motor_sel          <= 2'h0;
         pid_gain_set       <= 1'b0;
         current_limit_hold <= 1'b0;
         cmd_source         <= DIF_CMD_PANEL;
         term_mode          <= DIF_TERM_TWO1;
         fault_action       <= 4'h0;
      end
      else
      begin
         if (fn_on[DIF_FN_TORQUE_BLOCK])
            ctrl_mode <= DIF_MODE_SPEED;
         else
            ctrl_mode <= config_reg[DIF_CFG_CTRL] ^ fn_on[DIF_FN_MODE_SWITCH];
         pulse_input_en <= fn_on[DIF_FN_PULSE_IN];
         freq_mod_block <= fn_on[DIF_FN_FREQ_LOCK];
         pid_reverse    <= config_reg[DIF_CFG_PID_DIR] ^ fn_on[DIF_FN_PID_REV];
         pid_int_pause  <= fn_on[DIF_FN_PID_INT_HOLD];
         freq_x_preset  <= fn_on[DIF_FN_X_PRESET];
         freq_y_preset  <= fn_on[DIF_FN_Y_PRESET];
         motor_sel      <= {fn_on[DIF_FN_MOTOR_BIT1], fn_on[DIF_FN_MOTOR_BIT0]};
         pid_gain_set   <= (config_reg[DIF_CFG_PID_SRC] == DIF_PID_SRC_TERM)
                           && fn_on[DIF_FN_PID_GAIN];
         current_limit_hold <= fn_on[DIF_FN_ESTOP];
         if (cfg_cmd == DIF_CMD_TERMINAL && fn_on[DIF_FN_CMD_SWITCH])
            cmd_source <= DIF_CMD_COMM;
         else
            cmd_source <= cfg_cmd;
         if (cfg_term == DIF_TERM_TWO1 && fn_on[DIF_FN_LINE_SWITCH])
            term_mode <= DIF_TERM_THREE1;
         else
            term_mode <= cfg_term;
         fault_action <= config_reg[DIF_CFG_ACT_LO +: 4];
      end
   end

   // Event pulses
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         dc_brake_now   <= 1'b0;
         panel_stop     <= 1'b0;
         estop          <= 1'b0;
         decel_stop     <= 1'b0;
         decel_time_sel <= 2'h0;
         decel_dc_brake <= 1'b0;
         run_time_clear <= 1'b0;
      end
      else
      begin
         dc_brake_now   <= fn_rise[DIF_FN_DC_NOW];
         panel_stop     <= fn_rise[DIF_FN_PANEL_STOP] && cfg_cmd == DIF_CMD_PANEL;
         estop          <= fn_rise[DIF_FN_ESTOP];
         decel_stop     <= fn_rise[DIF_FN_DECEL_STOP];
         decel_dc_brake <= fn_rise[DIF_FN_DECEL_DC];
         run_time_clear <= fn_rise[DIF_FN_RT_CLEAR] && config_reg[DIF_CFG_RT_EN]
                           && rt_limit != 16'h0000;
         if (fn_rise[DIF_FN_DECEL_STOP])
            decel_time_sel <= DIF_DECEL_TIME4;
      end
   end

   // Fault reports, external fault first
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         fault_report <= 1'b0;
         fault_stop   <= 1'b0;
         fault_code   <= 8'h00;
      end
      else
      begin
         fault_report <= fn_rise[DIF_FN_EXT_FAULT] | fn_rise[DIF_FN_USER_FAULT1]
                         | fn_rise[DIF_FN_USER_FAULT2];
         fault_stop   <= fn_rise[DIF_FN_EXT_FAULT];
         if (fn_rise[DIF_FN_EXT_FAULT])
            fault_code <= DIF_EXTERNAL_FAULT_CODE;
         else if (fn_rise[DIF_FN_USER_FAULT1])
            fault_code <= DIF_USER_FAULT_ONE_CODE;
         else if (fn_rise[DIF_FN_USER_FAULT2])
            fault_code <= DIF_USER_FAULT_TWO_CODE;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence seq_estop_rise;
      !fn_on[DIF_FN_ESTOP] ##1 fn_on[DIF_FN_ESTOP];
   endsequence

   sequence seq_ext_rise;
      !fn_on[DIF_FN_EXT_FAULT] ##1 fn_on[DIF_FN_EXT_FAULT];
   endsequence

   chk_torque_block: assert property (
      fn_on[DIF_FN_TORQUE_BLOCK] |=> ctrl_mode == DIF_MODE_SPEED)
      else $error("torque block did not force speed mode");

   chk_pulse_fifth: assert property (
      pulse_input_en |-> $past(di_state[DIF_PULSE_DI_IDX]
                               && func_sel[DIF_PULSE_DI_IDX] == DIF_FN_PULSE_IN))
      else $error("pulse input enabled from wrong input");

   chk_dc_now: assert property (
      fn_rise[DIF_FN_DC_NOW] |=> dc_brake_now ##1 !dc_brake_now)
      else $error("immediate DC braking pulse wrong");

   chk_ext_fault: assert property (
      seq_ext_rise |=> fault_report && fault_stop && fault_code == DIF_EXTERNAL_FAULT_CODE)
      else $error("external fault not reported");

   chk_freq_lock: assert property (
      fn_on[DIF_FN_FREQ_LOCK] [*2] |-> freq_mod_block)
      else $error("frequency modification not blocked");

   chk_pid_reverse: assert property (
      ##1 pid_reverse == $past(config_reg[DIF_CFG_PID_DIR] ^ fn_on[DIF_FN_PID_REV]))
      else $error("PID direction wrong");

   chk_panel_stop: assert property (
      panel_stop |-> $past(cfg_cmd == DIF_CMD_PANEL && fn_rise[DIF_FN_PANEL_STOP]))
      else $error("panel stop outside panel mode");

   chk_cmd_switch: assert property (
      cfg_cmd == DIF_CMD_TERMINAL && fn_on[DIF_FN_CMD_SWITCH] && $stable(config_reg)
      |=> cmd_source == DIF_CMD_COMM)
      else $error("command source not switched");

   chk_motor_code: assert property (
      ##1 motor_sel == $past({fn_on[DIF_FN_MOTOR_BIT1], fn_on[DIF_FN_MOTOR_BIT0]}))
      else $error("motor selection code wrong");

   chk_estop_hold: assert property (
      seq_estop_rise |=> estop && current_limit_hold)
      else $error("emergency stop not raised");

   chk_line_switch: assert property (
      cfg_term == DIF_TERM_TWO1 && fn_on[DIF_FN_LINE_SWITCH] |=> term_mode == DIF_TERM_THREE1)
      else $error("line mode not switched");

endmodule // dif_decoder

// [dif_switch_bank.sv]
`timescale 1ns/1ps
module dif_switch_bank
   import dif_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   // Commanded contact positions
   input  wire logic [DIF_NUM_DI-1:0] level_cmd,
   input  wire logic [3:0]            bounce_len,
   // Terminal levels
   output logic      [DIF_NUM_DI-1:0] di_pin
);
   logic [DIF_NUM_DI-1:0] target;
   logic [3:0]            chatter [DIF_NUM_DI];

   // Contact chatter after each change
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         target <= '0;
         di_pin <= '0;
         for (int i = 0; i < DIF_NUM_DI; i++)
            chatter[i] <= 4'h0;
      end
      else
      begin
         for (int i = 0; i < DIF_NUM_DI; i++)
         begin
            if (level_cmd[i] != target[i])
            begin
               target[i]  <= level_cmd[i];
               chatter[i] <= bounce_len;
               di_pin[i]  <= ~di_pin[i];
            end
            else if (chatter[i] != 4'h0)
            begin
               chatter[i] <= chatter[i] - 4'h1;
               di_pin[i]  <= ~di_pin[i];
            end
            else
               di_pin[i] <= target[i];
         end
      end
   end
endmodule // dif_switch_bank

// [tb_digital_input_function_decoder.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      tests_run++; \
      if ((got) !== (ex)) \
      begin \
         error_cnt++; \
         $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
      end \
   end
module tb_digital_input_function_decoder;
   import dif_pkg::*;
   logic                  clk_sys   = 1'b0;
   logic                  rst       = 1'b1;
   logic [DIF_ADDR_W-1:0] reg_addr  = '0;
   logic [DIF_DATA_W-1:0] reg_wdata = '0;
   logic                  reg_wr    = 1'b0;
   logic                  reg_rd    = 1'b0;
   logic [DIF_NUM_DI-1:0] sw_cmd    = '0;
   logic [3:0]            bounce    = 4'h0;
   logic [DIF_DATA_W-1:0] reg_rdata;
   logic [DIF_NUM_DI-1:0] di_pin;
   logic                  ctrl_mode, pulse_input_en, dc_brake_now, fault_report, fault_stop;
   logic                  freq_mod_block, pid_reverse, panel_stop, pid_int_pause;
   logic                  freq_x_preset, freq_y_preset, pid_gain_set, estop;
   logic                  current_limit_hold, decel_stop, decel_dc_brake, run_time_clear;
   logic [7:0]            fault_code;
   logic [3:0]            fault_action;
   logic [1:0]            cmd_source, motor_sel, decel_time_sel, term_mode;
   logic [7:0]            pv, lv;
   int                    pcnt [8];
   int                    error_cnt = 0;
   int                    tests_run = 0;

   always #2 clk_sys = ~clk_sys;

   dif_switch_bank sw_u (.clk_sys(clk_sys), .rst(rst), .level_cmd(sw_cmd),
      .bounce_len(bounce), .di_pin(di_pin));

   dif_decoder #(.CYC_PER_MS(10)) dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .di_pin(di_pin), .ctrl_mode(ctrl_mode), .pulse_input_en(pulse_input_en),
      .dc_brake_now(dc_brake_now), .fault_report(fault_report), .fault_code(fault_code),
      .fault_action(fault_action), .fault_stop(fault_stop), .freq_mod_block(freq_mod_block),
      .pid_reverse(pid_reverse), .panel_stop(panel_stop), .cmd_source(cmd_source),
      .pid_int_pause(pid_int_pause), .freq_x_preset(freq_x_preset),
      .freq_y_preset(freq_y_preset), .motor_sel(motor_sel), .pid_gain_set(pid_gain_set),
      .estop(estop), .current_limit_hold(current_limit_hold), .decel_stop(decel_stop),
      .decel_time_sel(decel_time_sel), .decel_dc_brake(decel_dc_brake),
      .run_time_clear(run_time_clear), .term_mode(term_mode));

   assign pv = {run_time_clear, decel_dc_brake, decel_stop, estop, panel_stop, fault_stop,
                fault_report, dc_brake_now};
   assign lv = {freq_mod_block, pid_int_pause, freq_x_preset, freq_y_preset,
                current_limit_hold, pid_reverse, pulse_input_en, pid_gain_set};

   // Cycles each pulse output stands high
   always @(posedge clk_sys)
      for (int i = 0; i < 8; i++)
         if (pv[i] === 1'b1)
            pcnt[i]++;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", ex, reg_rdata)
      @(posedge clk_sys);
      #1;
      `CHK("reg_rdata idle", 32'h0, reg_rdata)
   endtask

   task automatic on(input int idx, input logic [5:0] fn);
      foreach (pcnt[i]) pcnt[i] = 0;
      wr(8'(idx * 4), 32'(fn));
      @(posedge clk_sys);
      sw_cmd[idx] <= 1'b1;
      tick(8);
   endtask

   task automatic off(input int idx);
      @(posedge clk_sys);
      sw_cmd[idx] <= 1'b0;
      tick(8);
      wr(8'(idx * 4), 32'h0);
      #1;
   endtask

   task automatic pulse_case(input logic [5:0] fn, input logic [7:0] ex);
      on(0, fn);
      off(0);
      for (int i = 0; i < 8; i++)
         `CHK("pulse count", int'(ex[i]), pcnt[i])
   endtask

   task automatic lvl_case(input int idx, input logic [5:0] fn, input logic [7:0] ex_on,
                           input logic [7:0] ex_off);
      on(idx, fn);
      `CHK("levels on", ex_on, lv)
      off(idx);
      tick(2);
      `CHK("levels off", ex_off, lv)
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #400000;
      error_cnt++;
      end_sim();
   end

   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(DIF_REG_FILTER, 32'h0000000A);
      rd_chk(DIF_REG_CONFIG, 32'h0);
      rd_chk(8'h3C, 32'h0);
      wr(DIF_REG_FILTER, 32'h0);
      pulse_case(DIF_FN_DC_NOW, 8'h01);
      pulse_case(DIF_FN_EXT_FAULT, 8'h06);
      `CHK("fault_code", DIF_EXTERNAL_FAULT_CODE, fault_code)
      pulse_case(DIF_FN_USER_FAULT1, 8'h02);
      `CHK("fault_code", DIF_USER_FAULT_ONE_CODE, fault_code)
      pulse_case(DIF_FN_USER_FAULT2, 8'h02);
      `CHK("fault_code", DIF_USER_FAULT_TWO_CODE, fault_code)
      pulse_case(DIF_FN_PANEL_STOP, 8'h08);
      pulse_case(DIF_FN_ESTOP, 8'h10);
      pulse_case(DIF_FN_DECEL_DC, 8'h40);
      pulse_case(DIF_FN_RT_CLEAR, 8'h00);
      pulse_case(DIF_FN_RESERVED, 8'h00);
      pulse_case(6'h34, 8'h00);
      wr(DIF_REG_RT_LIMIT, 32'h5);
      wr(DIF_REG_CONFIG, 32'h80);
      pulse_case(DIF_FN_RT_CLEAR, 8'h80);
      for (int c = 0; c < 3; c++)
      begin
         wr(DIF_REG_CONFIG, 32'(c << 3));
         pulse_case(DIF_FN_DECEL_STOP, 8'h20);
         `CHK("decel_time_sel", DIF_DECEL_TIME4, decel_time_sel)
      end
      wr(DIF_REG_CONFIG, 32'h8);
      pulse_case(DIF_FN_PANEL_STOP, 8'h00);
      on(0, DIF_FN_CMD_SWITCH);
      `CHK("cmd_source", DIF_CMD_COMM, cmd_source)
      off(0);
      `CHK("cmd_source", DIF_CMD_TERMINAL, cmd_source)
      wr(DIF_REG_CONFIG, 32'h0);
      lvl_case(0, DIF_FN_CMD_SWITCH, 8'h00, 8'h00);
      `CHK("cmd_source", DIF_CMD_PANEL, cmd_source)
      lvl_case(0, DIF_FN_FREQ_LOCK, 8'h80, 8'h00);
      lvl_case(0, DIF_FN_PID_INT_HOLD, 8'h40, 8'h00);
      lvl_case(0, DIF_FN_X_PRESET, 8'h20, 8'h00);
      lvl_case(0, DIF_FN_Y_PRESET, 8'h10, 8'h00);
      lvl_case(0, DIF_FN_ESTOP, 8'h08, 8'h00);
      lvl_case(0, DIF_FN_PID_REV, 8'h04, 8'h00);
      lvl_case(0, DIF_FN_PULSE_IN, 8'h00, 8'h00);
      lvl_case(DIF_PULSE_DI_IDX, DIF_FN_PULSE_IN, 8'h02, 8'h00);
      lvl_case(0, DIF_FN_PID_GAIN, 8'h00, 8'h00);
      wr(DIF_REG_CONFIG, 32'h2);
      lvl_case(0, DIF_FN_PID_GAIN, 8'h01, 8'h00);
      wr(DIF_REG_CONFIG, 32'h1);
      lvl_case(0, DIF_FN_PID_REV, 8'h00, 8'h04);
      for (int c = 0; c < 2; c++)
      begin
         wr(DIF_REG_CONFIG, 32'(c << 2));
         on(0, DIF_FN_MODE_SWITCH);
         `CHK("ctrl_mode", 1'(1 - c), ctrl_mode)
         on(1, DIF_FN_TORQUE_BLOCK);
         `CHK("ctrl_mode", DIF_MODE_SPEED, ctrl_mode)
         off(1);
         off(0);
         `CHK("ctrl_mode", 1'(c), ctrl_mode)
      end
      wr(DIF_REG_CONFIG, 32'h0);
      on(0, DIF_FN_LINE_SWITCH);
      `CHK("term_mode", DIF_TERM_THREE1, term_mode)
      off(0);
      wr(DIF_REG_CONFIG, 32'h20);
      on(0, DIF_FN_LINE_SWITCH);
      `CHK("term_mode", 2'h1, term_mode)
      off(0);
      wr(DIF_REG_CONFIG, 32'hA00);
      tick(2);
      `CHK("fault_action", 4'hA, fault_action)
      wr(8'h00, 32'(DIF_FN_MOTOR_BIT0));
      wr(8'h04, 32'(DIF_FN_MOTOR_BIT1));
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk_sys);
         sw_cmd[1:0] <= 2'(m);
         tick(8);
         `CHK("motor_sel", 2'(m), motor_sel)
      end
      rd_chk(DIF_REG_INPUTS, 32'h3);
      off(1);
      off(0);
      // Short glitch, then a bouncing contact, behind a 2 ms filter
      wr(DIF_REG_FILTER, 32'h2);
      on(0, DIF_FN_DC_NOW);
      @(posedge clk_sys);
      sw_cmd[0] <= 1'b0;
      tick(60);
      `CHK("glitch pulses", 0, pcnt[0])
      @(posedge clk_sys);
      bounce    <= 4'h3;
      sw_cmd[0] <= 1'b1;
      tick(8);
      `CHK("early pulses", 0, pcnt[0])
      for (int k = 0; k < 60 && pcnt[0] == 0; k++)
         tick(1);
      tick(10);
      `CHK("filtered pulses", 1, pcnt[0])
      end_sim();
   end
endmodule // tb_digital_input_function_decoder
